// *** core/uart_regs_pkg.sv ***
// Constants, codes and carrier types for the UART channel register block
package uart_regs_pkg;
   localparam int FIFO_DEPTH = 64;
   localparam int LVL_W = 7;
   // Register addresses per bank
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_IIR_FCR = 3'h2;
   localparam logic [2:0] ADDR_LCR = 3'h3;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_TCR = 3'h6;
   localparam logic [2:0] ADDR_TLR = 3'h7;
   localparam logic [2:0] ADDR_FIFO_RDY = 3'h7;
   localparam logic [2:0] ADDR_DLL = 3'h0;
   localparam logic [2:0] ADDR_DLH = 3'h1;
   localparam logic [2:0] ADDR_EFR = 3'h2;
   localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
   localparam int LCR_DIV_BIT = 7;
   // Field positions
   localparam int IER_RHR = 0;
   localparam int IER_THR = 1;
   localparam int IER_LSR = 2;
   localparam int IER_MSR = 3;
   localparam int IER_SLEEP = 4;
   localparam int IER_XOFF = 5;
   localparam int IER_RTS = 6;
   localparam int IER_CTS = 7;
   localparam int EFR_WEN = 4;
   localparam int EFR_SPECIAL = 5;
   localparam int EFR_AUTO_RTS = 6;
   localparam int EFR_AUTO_CTS = 7;
   localparam int MCR_RTS = 1;
   localparam int MCR_RDY_EN = 2;
   localparam int MCR_LOOP = 4;
   localparam int MCR_TCR_EN = 6;
   localparam int FCR_EN = 0;
   // Masks of bits that only change while the write enable is set
   localparam logic [7:0] IER_GATED = 8'hf0;
   localparam logic [7:0] FCR_GATED = 8'h30;
   localparam logic [7:0] MCR_GATED = 8'he0;
   localparam logic [7:0] REG_RST = 8'h00;
   // Identification codes, bits 5:0
   localparam logic [5:0] IIR_NONE = 6'h01;
   localparam logic [5:0] IIR_LSE = 6'h06;
   localparam logic [5:0] IIR_RXTO = 6'h0c;
   localparam logic [5:0] IIR_RHR = 6'h04;
   localparam logic [5:0] IIR_THR = 6'h02;
   localparam logic [5:0] IIR_MSR = 6'h00;
   localparam logic [5:0] IIR_XOFF = 6'h10;
   localparam logic [5:0] IIR_CTSRTS = 6'h20;
   // Fallback trigger levels selected by the FIFO control field
   localparam logic [3:0][LVL_W-1:0] TX_TRIG_TAB =
      {7'h38, 7'h20, 7'h10, 7'h08};
   localparam logic [3:0][LVL_W-1:0] RX_TRIG_TAB =
      {7'h3c, 7'h38, 7'h10, 7'h08};
   localparam int TX_SEL_LSB = 4;
   localparam int RX_SEL_LSB = 6;

   typedef struct packed {
      logic line_err;               // Receiver line status error
      logic rx_timeout;             // Receive timeout
      logic modem_chg;              // Modem status change
      logic xoff_rx;                // Xoff character received
      logic rx_valid;               // Received character strobe
      logic [7:0] rx_char;          // Received character
      logic [LVL_W-1:0] rx_level;   // Characters in receive FIFO
      logic [LVL_W-1:0] tx_level;   // Characters in transmit FIFO
      logic thr_write;              // Host wrote transmit holding
   } engine_status_type;
endpackage : uart_regs_pkg

// *** core/trigger_level_sel.sv ***
// Resolves one effective FIFO trigger level from override field and table
`timescale 1ns/1ps
module trigger_level_sel
   import uart_regs_pkg::*;
#(
   parameter int LW = LVL_W
) (
   input wire logic [3:0] i_field,            // Override level divided by 4
   input wire logic [1:0] i_sel,              // Fallback table index
   input wire logic [3:0][LW-1:0] i_table,    // Fallback table
   output logic [LW-1:0] o_level              // Effective level
);
   initial begin
      if (LW < 6) $error("trigger_level_sel: LW too small for 60");
   end
   wire logic [LW-1:0] field_level = LW'({i_field, 2'b00});
   assign o_level = (i_field == 4'h0) ? i_table[i_sel] : field_level;
endmodule : trigger_level_sel

// *** core/uart_irq_flow_trigger_regs.sv ***
// Channel register set: interrupt id, enhanced features, divisor, levels
`timescale 1ns/1ps
module uart_irq_flow_trigger_regs
   import uart_regs_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_ref_clk,                 // 40 MHz clock
   input wire logic i_rst,                     // Sync reset, active high
   input wire logic i_cs_a_n,                  // This channel select
   input wire logic i_cs_b_n,                  // Other channel select
   input wire logic [2:0] i_addr,              // Register address
   input wire logic i_wr,                      // Write strobe, one cycle
   input wire logic i_rd,                      // Read strobe, one cycle
   input wire logic [7:0] i_wdata,             // Write data
   input wire engine_status_type i_eng,        // Serial engine status
   input wire logic [7:0] i_xoff2_char,        // Second Xoff character
   input wire logic i_b_tx_ready,              // Channel B transmit ready
   input wire logic i_b_rx_ready,              // Channel B receive ready
   input wire logic i_cts_n,                   // CTS pin, asynchronous
   output logic [7:0] o_rdata,                 // Read data
   output logic o_int_pending,                 // Enabled interrupt pending
   output logic [15:0] o_divisor,              // Baud divisor
   output logic [3:0] o_sw_flow,               // Software flow selection
   output logic o_rts_n,                       // RTS pin level
   output logic o_tx_halt,                     // Stop new transmission
   output logic o_special_match,               // Special char seen, pulse
   output logic o_tx_ready,                    // Transmit space at level
   output logic o_rx_ready,                    // Receive above level
   output logic [7:0] o_ier,                   // Interrupt enable
   output logic [7:0] o_fcr,                   // FIFO control
   output logic [7:0] o_lcr,                   // Line control
   output logic [7:0] o_mcr                    // Modem control
);
   initial begin
      if (DEPTH > 127 || DEPTH < 60) $error("DEPTH out of range");
   end

   logic [7:0] ier_q, fcr_q, lcr_q, mcr_q, efr_q, dll_q, dlh_q, tcr_q, tlr_q;
   logic [7:0] rdata_q;
   logic cts_m_q, cts_s_q, cts_d_q;
   logic rts_n_q, rts_hi_d_q, tx_halt_q, match_q;
   logic thr_pend_q, xoff_pend_q, cts_pend_q, rts_pend_q;
   logic tx_rdy_q, rx_rdy_q, int_q, tx_rdy_prev_q;

   // Address decode
   wire logic sel_a = ~i_cs_a_n;
   wire logic enh_bank = (lcr_q == LCR_ENH_KEY);
   wire logic div_bank = lcr_q[LCR_DIV_BIT] & ~enh_bank;
   wire logic nrm_bank = ~lcr_q[LCR_DIV_BIT];
   wire logic tcr_mode = efr_q[EFR_WEN] & mcr_q[MCR_TCR_EN];
   wire logic hit_ier = nrm_bank & (i_addr == ADDR_IER);
   wire logic hit_iir = nrm_bank & (i_addr == ADDR_IIR_FCR);
   wire logic hit_lcr = (i_addr == ADDR_LCR);
   wire logic hit_mcr = nrm_bank & (i_addr == ADDR_MCR);
   wire logic hit_efr = enh_bank & (i_addr == ADDR_EFR);
   wire logic hit_dll = (div_bank | enh_bank) & (i_addr == ADDR_DLL);
   wire logic hit_dlh = (div_bank | enh_bank) & (i_addr == ADDR_DLH);
   wire logic hit_tcr = nrm_bank & tcr_mode & (i_addr == ADDR_TCR);
   wire logic hit_tlr = nrm_bank & tcr_mode & (i_addr == ADDR_TLR);
   wire logic rdy_ok = (~i_cs_a_n | ~i_cs_b_n) & mcr_q[MCR_RDY_EN] &
      ~mcr_q[MCR_LOOP] & nrm_bank & ~tcr_mode;
   wire logic hit_rdy = rdy_ok & (i_addr == ADDR_FIFO_RDY);
   wire logic wr_a = i_wr & sel_a;
   wire logic rd_a = i_rd & sel_a;

   wire logic [7:0] ier_keep = efr_q[EFR_WEN] ? 8'h00 : IER_GATED;
   wire logic [7:0] fcr_keep = efr_q[EFR_WEN] ? 8'h00 : FCR_GATED;
   wire logic [7:0] mcr_keep = efr_q[EFR_WEN] ? 8'h00 : MCR_GATED;
   wire logic [7:0] ier_d = (ier_q & ier_keep) | (i_wdata & ~ier_keep);
   wire logic [7:0] fcr_d = (fcr_q & fcr_keep) | (i_wdata & ~fcr_keep);
   wire logic [7:0] mcr_d = (mcr_q & mcr_keep) | (i_wdata & ~mcr_keep);
   wire logic div_wen = wr_a & ~ier_q[IER_SLEEP];

   logic [LVL_W-1:0] tx_trig, rx_trig;
   trigger_level_sel #(.LW(LVL_W)) u_tx_trig (
      .i_field(tlr_q[3:0]),
      .i_sel(fcr_q[TX_SEL_LSB+:2]),
      .i_table(TX_TRIG_TAB),
      .o_level(tx_trig)
   );
   trigger_level_sel #(.LW(LVL_W)) u_rx_trig (
      .i_field(tlr_q[7:4]),
      .i_sel(fcr_q[RX_SEL_LSB+:2]),
      .i_table(RX_TRIG_TAB),
      .o_level(rx_trig)
   );
   wire logic [LVL_W-1:0] tx_space = LVL_W'(DEPTH) - i_eng.tx_level;
   wire logic tx_rdy_d = (tx_space >= tx_trig);
   wire logic rx_rdy_d = (i_eng.rx_level > rx_trig) | i_eng.rx_timeout;
   wire logic rhr_lvl = (i_eng.rx_level >= rx_trig);

   wire logic [LVL_W-1:0] halt_lvl = LVL_W'({tcr_q[3:0], 2'b00});
   wire logic [LVL_W-1:0] rest_lvl = LVL_W'({tcr_q[7:4], 2'b00});
   wire logic rts_hi_d = ~efr_q[EFR_AUTO_RTS] ? 1'b0 :
      (i_eng.rx_level >= halt_lvl) ? 1'b1 :
      (i_eng.rx_level <= rest_lvl) ? 1'b0 : rts_hi_d_q;
   wire logic rts_n_d = efr_q[EFR_AUTO_RTS] ? rts_hi_d : ~mcr_q[MCR_RTS];

   // Enabled interrupt sources
   wire logic src_lse = ier_q[IER_LSR] & i_eng.line_err;
   wire logic src_rxto = ier_q[IER_RHR] & i_eng.rx_timeout;
   wire logic src_rhr = ier_q[IER_RHR] & rhr_lvl;
   wire logic src_thr = ier_q[IER_THR] & thr_pend_q;
   wire logic src_msr = ier_q[IER_MSR] & i_eng.modem_chg;
   wire logic src_xoff = ier_q[IER_XOFF] & xoff_pend_q;
   wire logic src_cr = (ier_q[IER_CTS] & cts_pend_q) |
      (ier_q[IER_RTS] & rts_pend_q);
   wire logic [5:0] iir_code = src_lse ? IIR_LSE : src_rxto ? IIR_RXTO :
      src_rhr ? IIR_RHR : src_thr ? IIR_THR : src_msr ? IIR_MSR :
      src_xoff ? IIR_XOFF : src_cr ? IIR_CTSRTS : IIR_NONE;
   wire logic [7:0] iir_val = {{2{fcr_q[FCR_EN]}}, iir_code};
   wire logic iir_rd = rd_a & hit_iir;

   wire logic sp_hit = efr_q[EFR_SPECIAL] & i_eng.rx_valid &
      (i_eng.rx_char == i_xoff2_char);
   wire logic thr_reen = wr_a & hit_ier & ~ier_q[IER_THR] & i_wdata[IER_THR];
   wire logic thr_set = (tx_rdy_d & ~tx_rdy_prev_q) | (thr_reen & tx_rdy_d);
   wire logic thr_clr = i_eng.thr_write | (iir_rd & iir_code == IIR_THR);
   wire logic xoff_set = sp_hit | i_eng.xoff_rx;
   wire logic cr_clr = iir_rd & (iir_code == IIR_CTSRTS);
   wire logic cts_rise = cts_s_q & ~cts_d_q;
   wire logic rts_rise = rts_n_d & ~rts_n_q;

   wire logic [7:0] rdy_val = {2'b00, i_b_rx_ready, rx_rdy_q,
      2'b00, i_b_tx_ready, tx_rdy_q};
   wire logic [7:0] rd_val = hit_rdy ? rdy_val :
      ~sel_a ? REG_RST :
      hit_tcr ? tcr_q : hit_tlr ? tlr_q : hit_efr ? efr_q :
      hit_dll ? dll_q : hit_dlh ? dlh_q : hit_lcr ? lcr_q :
      hit_ier ? ier_q : hit_iir ? iir_val : hit_mcr ? mcr_q : REG_RST;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ier_q <= REG_RST;
         fcr_q <= REG_RST;
         lcr_q <= REG_RST;
         mcr_q <= REG_RST;
         efr_q <= REG_RST;
         dll_q <= REG_RST;
         dlh_q <= REG_RST;
         tcr_q <= REG_RST;
         tlr_q <= REG_RST;
      end else if (wr_a) begin
         if (hit_tcr) tcr_q <= i_wdata;
         else if (hit_tlr) tlr_q <= i_wdata;
         else if (hit_efr) efr_q <= i_wdata;
         else if (hit_ier) ier_q <= ier_d;
         else if (hit_iir) fcr_q <= fcr_d;
         else if (hit_mcr) mcr_q <= mcr_d;
         else if (hit_lcr) lcr_q <= i_wdata;
         if (div_wen & hit_dll & ~hit_lcr) dll_q <= i_wdata;
         if (div_wen & hit_dlh) dlh_q <= i_wdata;
      end
   end

   // CTS pin crosses in through two flops; the second is read, and a third flop delays it for edge detection
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         // Inactive level, so a pin idling high makes no false edge
         cts_m_q <= 1'b1;
         cts_s_q <= 1'b1;
         cts_d_q <= 1'b1;
      end else begin
         cts_m_q <= i_cts_n;
         cts_s_q <= cts_m_q;
         cts_d_q <= cts_s_q;
      end
   end

   // Pending flags: a set in the clearing cycle wins
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         thr_pend_q <= 1'b0;
         xoff_pend_q <= 1'b0;
         cts_pend_q <= 1'b0;
         rts_pend_q <= 1'b0;
      end else begin
         thr_pend_q <= thr_set | (thr_pend_q & ~thr_clr);
         xoff_pend_q <= xoff_set |
            (xoff_pend_q & ~(iir_rd & iir_code == IIR_XOFF));
         cts_pend_q <= cts_rise | (cts_pend_q & ~cr_clr);
         rts_pend_q <= rts_rise | (rts_pend_q & ~cr_clr);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rdata_q <= REG_RST;
         rts_n_q <= 1'b1;
         rts_hi_d_q <= 1'b0;
         tx_halt_q <= 1'b0;
         match_q <= 1'b0;
         tx_rdy_q <= 1'b0;
         rx_rdy_q <= 1'b0;
         tx_rdy_prev_q <= 1'b0;
         int_q <= 1'b0;
      end else begin
         if (i_rd) rdata_q <= rd_val;
         rts_n_q <= rts_n_d;
         rts_hi_d_q <= rts_hi_d;
         tx_halt_q <= efr_q[EFR_AUTO_CTS] & cts_s_q;
         match_q <= sp_hit;
         tx_rdy_q <= tx_rdy_d;
         rx_rdy_q <= rx_rdy_d;
         tx_rdy_prev_q <= tx_rdy_d;
         int_q <= (iir_code != IIR_NONE);
      end
   end

   assign o_rdata = rdata_q;
   assign o_int_pending = int_q;
   assign o_divisor = {dlh_q, dll_q};
   assign o_sw_flow = efr_q[3:0];
   assign o_rts_n = rts_n_q;
   assign o_tx_halt = tx_halt_q;
   assign o_special_match = match_q;
   assign o_tx_ready = tx_rdy_q;
   assign o_rx_ready = rx_rdy_q;
   assign o_ier = ier_q;
   assign o_fcr = fcr_q;
   assign o_lcr = lcr_q;
   assign o_mcr = mcr_q;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   wire logic any_src = src_lse | src_rxto | src_rhr | src_thr | src_msr |
      src_xoff | src_cr;
   property p_iir_bit0;
      i_rd & sel_a & hit_iir |=> o_rdata[0] == ~$past(any_src);
   endproperty
   a_iir_bit0: assert property (p_iir_bit0) else $error("bit0 wrong");
   property p_lse_top;
      iir_rd & src_lse |=> o_rdata[5:0] == IIR_LSE;
   endproperty
   a_lse_top: assert property (p_lse_top) else $error("lse lost");
   property p_thr_code;
      src_thr & ~src_lse & ~src_rxto & ~src_rhr |-> iir_val[5:0] == 6'h02;
   endproperty
   a_thr_code: assert property (p_thr_code) else $error("thr code");
   property p_cr_code;
      src_cr & ~(src_lse | src_rxto | src_rhr | src_thr | src_msr |
         src_xoff) |-> iir_code == 6'h20;
   endproperty
   a_cr_code: assert property (p_cr_code) else $error("cts/rts code");
   property p_mirror;
      iir_rd |=> o_rdata[7:6] == {2{$past(o_fcr[FCR_EN])}};
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror");
   property p_ier_gate;
      wr_a & hit_ier & ~efr_q[EFR_WEN] |=> $stable(ier_q[7:4]);
   endproperty
   a_ier_gate: assert property (p_ier_gate) else $error("ier gate");
   property p_special;
      sp_hit |=> xoff_pend_q && o_special_match;
   endproperty
   a_special: assert property (p_special) else $error("special");
   property p_rts_halt;
      efr_q[EFR_AUTO_RTS] & (i_eng.rx_level >= halt_lvl) |=> o_rts_n;
   endproperty
   a_rts_halt: assert property (p_rts_halt) else $error("rts halt");
   property p_cts;
      efr_q[EFR_AUTO_CTS] & cts_s_q |=> o_tx_halt;
   endproperty
   a_cts: assert property (p_cts) else $error("cts halt");
   property p_dl_lock;
      ier_q[IER_SLEEP] |=> $stable(o_divisor);
   endproperty
   a_dl_lock: assert property (p_dl_lock) else $error("divisor");
   property p_rdy;
      i_rd & hit_rdy |=> o_rdata[7:6] == 2'b00 && o_rdata[3:2] == 2'b00;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready bits");
   property p_reen;
      thr_reen & tx_rdy_d |=> thr_pend_q;
   endproperty
   a_reen: assert property (p_reen) else $error("thr re-enable");
   c_rdy_read: cover property (i_rd & hit_rdy);
   c_auto_rts: cover property (o_rts_n & efr_q[EFR_AUTO_RTS]);
   c_cr_report: cover property (iir_rd & iir_code == IIR_CTSRTS);
endmodule : uart_irq_flow_trigger_regs

// *** verification/host_bus_model.sv ***
// Host processor model that drives the parallel register port
`timescale 1ns/1ps
module host_bus_model (
   input wire logic i_ref_clk,       // Bus clock
   input wire logic [7:0] i_rdata,   // Read data from the block
   output logic o_cs_a_n,            // Channel A select
   output logic o_cs_b_n,            // Channel B select
   output logic [2:0] o_addr,        // Register address
   output logic o_wr,                // Write strobe
   output logic o_rd,                // Read strobe
   output logic [7:0] o_wdata        // Write data
);
   initial begin
      o_cs_a_n = 1'b1;
      o_cs_b_n = 1'b1;
      o_addr = 3'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end

   // Released lines carry inverted values so stale data never looks valid
   task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      o_cs_a_n <= 1'b0;
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_ref_clk);
      o_cs_a_n <= 1'b1;
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : write_reg

   task automatic read_reg(input logic [2:0] a, input logic use_b,
                           output logic [7:0] d);
      @(posedge i_ref_clk);
      o_cs_a_n <= use_b;
      o_cs_b_n <= ~use_b;
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_ref_clk);
      o_cs_a_n <= 1'b1;
      o_cs_b_n <= 1'b1;
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_ref_clk);
      #1 d = i_rdata;
   endtask : read_reg
endmodule : host_bus_model

// *** verification/uart_irq_flow_trigger_regs_tb_top.sv ***
// Self-checking bench for the channel register block
`timescale 1ns/1ps
module uart_irq_flow_trigger_regs_tb_top
   import uart_regs_pkg::*;
();
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_a_n, cs_b_n, wr, rd, int_pend, rts_n, tx_halt, special;
   logic tx_rdy, rx_rdy;
   logic b_tx_rdy = 1'b0;
   logic b_rx_rdy = 1'b0;
   logic cts_n = 1'b0;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, interrupt_enable, fifo_control, lcr, modem_control;
   logic [7:0] xoff2 = 8'h13;
   logic [15:0] divisor;
   logic [3:0] sw_flow;
   engine_status_type eng = '0;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   host_bus_model i_host_bus_model (
      .i_ref_clk(ref_clk), .i_rdata(rdata), .o_cs_a_n(cs_a_n),
      .o_cs_b_n(cs_b_n), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata)
   );

   uart_irq_flow_trigger_regs i_uart_irq_flow_trigger_regs (
      .i_ref_clk(ref_clk), .i_rst(rst), .i_cs_a_n(cs_a_n),
      .i_cs_b_n(cs_b_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
      .i_wdata(wdata), .i_eng(eng), .i_xoff2_char(xoff2),
      .i_b_tx_ready(b_tx_rdy), .i_b_rx_ready(b_rx_rdy),
      .i_cts_n(cts_n), .o_rdata(rdata), .o_int_pending(int_pend),
      .o_divisor(divisor), .o_sw_flow(sw_flow), .o_rts_n(rts_n),
      .o_tx_halt(tx_halt), .o_special_match(special),
      .o_tx_ready(tx_rdy), .o_rx_ready(rx_rdy), .o_ier(interrupt_enable),
      .o_fcr(fifo_control), .o_lcr(lcr), .o_mcr(modem_control)
   );

   task automatic wrap_up;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      i_host_bus_model.write_reg(a, d);
      #1;
   endtask : wr_reg

   task automatic rd_chk(input logic [2:0] a, input logic use_b,
                         input logic [7:0] exp, input string what);
      logic [7:0] d;
      i_host_bus_model.read_reg(a, use_b, d);
      chk(what, 16'(exp), 16'(d));
   endtask : rd_chk

   task automatic iir_chk(input logic [7:0] exp);
      rd_chk(ADDR_IIR_FCR, 1'b0, exp, "identification");
   endtask : iir_chk

   // Enhanced bank is opened by the key value and closed again
   task automatic set_efr(input logic [7:0] v);
      wr_reg(ADDR_LCR, LCR_ENH_KEY);
      wr_reg(ADDR_EFR, v);
      wr_reg(ADDR_LCR, 8'h00);
   endtask : set_efr

   task automatic t_gating;
      wr_reg(ADDR_IER, 8'hf5);
      chk("ier", 16'h05, 16'(interrupt_enable));
      wr_reg(ADDR_MCR, 8'he0);
      chk("mcr", 16'h00, 16'(modem_control));
      wr_reg(ADDR_IIR_FCR, 8'h31);
      chk("fcr", 16'h01, 16'(fifo_control));
      set_efr(8'h1a);
      chk("sw flow", 16'h0a, 16'(sw_flow));
      wr_reg(ADDR_IER, 8'hf5);
      chk("ier", 16'hf5, 16'(interrupt_enable));
      wr_reg(ADDR_IIR_FCR, 8'h31);
      chk("fcr", 16'h31, 16'(fifo_control));
      wr_reg(ADDR_IER, 8'h00);
      wr_reg(ADDR_IIR_FCR, 8'h00);
   endtask : t_gating

   task automatic t_irq;
      logic [15:0] n;
      n = 16'h0;
      @(posedge ref_clk);
      eng.line_err <= 1'b1;
      eng.rx_timeout <= 1'b1;
      eng.modem_chg <= 1'b1;
      eng.rx_level <= 7'd8;
      wr_reg(ADDR_IER, 8'h0d);
      settle(2);
      chk("pending", 16'h1, 16'(int_pend));
      iir_chk(8'h06);
      @(posedge ref_clk) eng.line_err <= 1'b0;
      iir_chk(8'h0c);
      @(posedge ref_clk) eng.rx_timeout <= 1'b0;
      iir_chk(8'h04);
      @(posedge ref_clk) eng.rx_level <= 7'd0;
      iir_chk(8'h00);
      // Clear the transmit flag so only the re-enable can raise it again
      @(posedge ref_clk);
      eng.modem_chg <= 1'b0;
      eng.thr_write <= 1'b1;
      @(posedge ref_clk) eng.thr_write <= 1'b0;
      wr_reg(ADDR_IER, 8'h0f);
      iir_chk(8'h02);
      iir_chk(8'h01);
      chk("pending", 16'h0, 16'(int_pend));
      set_efr(8'h30);
      wr_reg(ADDR_IER, 8'ha0);
      @(posedge ref_clk);
      eng.rx_char <= xoff2;
      eng.rx_valid <= 1'b1;
      cts_n <= 1'b1;
      repeat (5) begin
         @(posedge ref_clk);
         eng.rx_valid <= 1'b0;
         #1 n = n + 16'(special);
      end
      chk("special pulses", 16'h1, n);
      iir_chk(8'h10);
      iir_chk(8'h20);
      iir_chk(8'h01);
      @(posedge ref_clk);
      cts_n <= 1'b0;
      eng.xoff_rx <= 1'b1;
      @(posedge ref_clk) eng.xoff_rx <= 1'b0;
      iir_chk(8'h10);
      wr_reg(ADDR_IIR_FCR, 8'h01);
      iir_chk(8'hc1);
      set_efr(8'h10);
   endtask : t_irq

   task automatic t_divisor;
      wr_reg(ADDR_LCR, 8'h80);
      chk("lcr", 16'h80, 16'(lcr));
      wr_reg(ADDR_DLL, 8'h34);
      wr_reg(ADDR_DLH, 8'h12);
      chk("divisor", 16'h1234, divisor);
      // Sleep only after the divisor is loaded
      wr_reg(ADDR_LCR, 8'h00);
      wr_reg(ADDR_IER, 8'h10);
      wr_reg(ADDR_LCR, 8'h80);
      wr_reg(ADDR_DLL, 8'h77);
      wr_reg(ADDR_DLH, 8'h66);
      chk("divisor", 16'h1234, divisor);
      wr_reg(ADDR_LCR, 8'h00);
      wr_reg(ADDR_IER, 8'h00);
   endtask : t_divisor

   task automatic t_levels;
      wr_reg(ADDR_TCR, 8'h28);
      wr_reg(ADDR_MCR, 8'h40);
      rd_chk(ADDR_TCR, 1'b0, 8'h00, "threshold");
      // Halt level 32 kept above restore level 8
      wr_reg(ADDR_TCR, 8'h28);
      rd_chk(ADDR_TCR, 1'b0, 8'h28, "threshold");
      // Levels written divided by four: receive 12, transmit 4
      wr_reg(ADDR_TLR, 8'h31);
      set_efr(8'h00);
      wr_reg(ADDR_TLR, 8'h00);
      set_efr(8'h10);
      rd_chk(ADDR_TLR, 1'b0, 8'h31, "trigger");
   endtask : t_levels

   task automatic t_rts;
      logic [6:0] lv [4];
      logic [3:0] ex;
      lv = '{7'd0, 7'd32, 7'd9, 7'd8};
      ex = 4'b0110;
      set_efr(8'h50);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk) eng.rx_level <= lv[i];
         settle(3);
         chk("rts_n", 16'(ex[i]), 16'(rts_n));
      end
   endtask : t_rts

   task automatic t_cts;
      set_efr(8'h90);
      @(posedge ref_clk) cts_n <= 1'b1;
      settle(4);
      chk("tx halt", 16'h1, 16'(tx_halt));
      @(posedge ref_clk) cts_n <= 1'b0;
      settle(4);
      chk("tx halt", 16'h0, 16'(tx_halt));
      @(posedge ref_clk) cts_n <= 1'b1;
      set_efr(8'h10);
      chk("tx halt", 16'h0, 16'(tx_halt));
      @(posedge ref_clk) cts_n <= 1'b0;
   endtask : t_cts

   task automatic rdy_case(input logic [6:0] txl, input logic [6:0] rxl,
                           input logic [2:0] ext, input logic [7:0] exp);
      @(posedge ref_clk);
      eng.tx_level <= txl;
      eng.rx_level <= rxl;
      {eng.rx_timeout, b_tx_rdy, b_rx_rdy} <= ext;
      rd_chk(ADDR_FIFO_RDY, 1'b1, exp, "ready status");
      chk("ready outs", 16'({exp[0], exp[4]}),
         16'({tx_rdy, rx_rdy}));
   endtask : rdy_case

   task automatic t_ready;
      wr_reg(ADDR_MCR, 8'h04);
      rdy_case(7'd60, 7'd12, 3'b001, 8'h21);
      rdy_case(7'd61, 7'd13, 3'b010, 8'h12);
      wr_reg(ADDR_MCR, 8'h44);
      wr_reg(ADDR_TLR, 8'h00);
      wr_reg(ADDR_MCR, 8'h04);
      rdy_case(7'd56, 7'd8, 3'b100, 8'h11);
      rdy_case(7'd57, 7'd9, 3'b011, 8'h32);
      wr_reg(ADDR_MCR, 8'h14);
      rd_chk(ADDR_FIFO_RDY, 1'b1, 8'h00, "ready loopback");
   endtask : t_ready

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk("rts_n", 16'h1, 16'(rts_n));
      iir_chk(8'h01);
      t_gating();
      t_irq();
      t_divisor();
      t_levels();
      t_rts();
      t_cts();
      t_ready();
      wrap_up();
   end
endmodule : uart_irq_flow_trigger_regs_tb_top
